// file: core/flc_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the loop controller.
// Assumes: Included by the controller modules only.
// Notes: Device addresses are those of the first loop; the second sits one stride above.
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH

`define FLC_REG_CMD 8'h00
`define FLC_REG_CFG 8'h04
`define FLC_REG_SEL 8'h08
`define FLC_REG_MULT 8'h0C
`define FLC_REG_FRAC 8'h10
`define FLC_REG_REFKHZ 8'h14
`define FLC_REG_STATUS 8'h18

`define FLC_CMD_APPLY 0
`define FLC_CMD_DISABLE 1
`define FLC_CFG_LOOP 0
`define FLC_CFG_SYNC 1
`define FLC_CFG_LIVE 2
`define FLC_CFG_STEADY 3

`define FLC_DEV_CTRL1 16'h0171
`define FLC_DEV_CTRL2 16'h0172
`define FLC_DEV_CTRL3 16'h0173
`define FLC_DEV_CTRL4 16'h0174
`define FLC_DEV_CTRL5 16'h0175
`define FLC_DEV_CTRL6 16'h0176
`define FLC_DEV_CTRL7 16'h0179
`define FLC_DEV_SYNC1 16'h0181
`define FLC_DEV_SYNC6 16'h0186
`define FLC_DEV_STRIDE 16'h0020
`define FLC_DEV_ENA_BIT 0
`define FLC_DEV_FREERUN_BIT 1
`define FLC_DEV_UPD_BIT 15
`define FLC_DEV_RATIO_LSB 8
`define FLC_DEV_OUTDIV_LSB 1
`define FLC_DEV_PREDIV_LSB 6
`define FLC_DEV_GAIN_LSB 2

`define FLC_RST_N 10'h008
`define FLC_RST_THETA 16'h0018
`define FLC_RST_LAMBDA 16'h007D
`define FLC_RST_OUTDIV 3'h2

`define FLC_GAIN_X16 4'h4
`define FLC_GAIN_X4 4'h2
`define FLC_GAIN_X1 4'h0
`define FLC_KHZ_GAIN16 18'd1000
`define FLC_KHZ_GAIN4 18'd256
`define FLC_KHZ_REF_MAX 18'd13500
`define FLC_KHZ_VCO_MIN 36'd90000
`define FLC_KHZ_VCO_MAX 36'd100000
`define FLC_OUTDIV_MIN 3'h2

`define FLC_SETTLE_NS 32000
`define FLC_CLK_PERIOD_PS 5000
`define FLC_LAST_STEP 4'hC

`endif

// file: core/flc_pkg.sv
// Purpose: Types shared by the loop controller modules.
// Assumes: Nothing beyond the parameter header.
// Notes: Sequencer states only.
package flc_pkg;
    typedef enum logic [1:0] {
        FLC_IDLE = 2'b00,
        FLC_STEP = 2'b01,
        FLC_WRITE = 2'b10,
        FLC_WAIT = 2'b11
    } flc_state_t;
endpackage

// file: core/flc_devwr.sv
// Purpose: Issues one device register write and waits for its acknowledge.
// Assumes: The device control port runs on clk and answers with a one-cycle ack.
// Notes: Request, address and data come straight from flip-flops.
`timescale 1ns/1ps
module flc_devwr #(
    parameter int AW = 16,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] data,
    output logic done,
    output logic dev_req,
    output logic [AW-1:0] dev_addr,
    output logic [DW-1:0] dev_wdata,
    input wire logic dev_ack
);
    logic req_r, req_nxt, done_r, done_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    logic [DW-1:0] data_r, data_nxt;

    always_comb begin
        req_nxt = req_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        done_nxt = 1'b0;
        if (req_r && dev_ack) begin
            req_nxt = 1'b0;
            done_nxt = 1'b1;
        end else if (!req_r && start) begin
            req_nxt = 1'b1;
            addr_nxt = addr;
            data_nxt = data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_r <= 1'b0;
            done_r <= 1'b0;
            addr_r <= '0;
            data_r <= '0;
        end else begin
            req_r <= req_nxt;
            done_r <= done_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
        end
    end

    assign done = done_r;
    assign dev_req = req_r;
    assign dev_addr = addr_r;
    assign dev_wdata = data_r;

    req_holds_a: assert property (@(posedge clk) disable iff (rst)
        req_r && !dev_ack |=> req_r && $stable(addr_r) && $stable(data_r))
        else $error("device request dropped before ack");
endmodule

// file: core/flc_ctrl.sv
// Purpose: Host controller that configures and enables one of two frequency-locked loops.
// Assumes: APB slave on clk; device registers written through a simple write port.
// Notes: One loop is driven per sequence; the rules follow.
// Function
// R01: Synchroniser only with a steady main reference.
// R02: Loop enable written last in sequence.
// R03: Clear loop enable before changing synchroniser.
// R04: Device free-runs once established; nothing here.
// R05: Set free-run before clearing loop enable.
// R06: Live change: free-run, wait 32us, hold.
// R07: Default change path disables then re-enables.
// R08: Live multiplier writes need the update strobe.
// R09: Disabled loop takes multiplier writes directly.
// R10: Two loops, each with own enables.
// R11: Reference selectors pick valid sources independently.
// R12: Bus clock reference divided adaptively by device.
// R13: Pre-divider brings reference to 13.5MHz.
// R14: Oscillator is reference times N.K times ratio.
// R15: Oscillator kept between 90 and 100MHz.
// R16: Output divider restricted to codes 2 to 7.
// R17: Gain chosen from reference frequency band.
// R18: Ratio field value plus one is division.
// R19: Integer N.K flagged for odd ratio change.
// R20: Divided reference below the per-ratio limit.
// R21: Multiplier fields are plain unsigned integers.
// R22: Steady clock main, accurate clock synchroniser.
// R23: Update strobe writes once and reads zero.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "flc_params.svh"
module flc_ctrl import flc_pkg::*; #(
    parameter int SETTLE_CYCLES =
        (`FLC_SETTLE_NS * 1000 + `FLC_CLK_PERIOD_PS - 1) / `FLC_CLK_PERIOD_PS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic dev_req,
    output logic [15:0] dev_addr,
    output logic [15:0] dev_wdata,
    input wire logic dev_ack
);
    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions.
    function automatic logic src_ok(input logic [3:0] code, input logic loop);
        logic ok;
        ok = 1'b0;
        unique case (code)
            4'h0, 4'h1, 4'h3, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE: ok = 1'b1;
            4'h4: ok = loop;
            4'h5: ok = !loop;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic [17:0] ratio_limit(input logic [3:0] code);
        logic [17:0] lim;
        lim = 18'd768;
        if (code == 4'h0) begin
            lim = `FLC_KHZ_REF_MAX;
        end else if (code == 4'h1) begin
            lim = 18'd6144;
        end else if (code <= 4'h3) begin
            lim = 18'd3072;
        end else if (code <= 4'h5) begin
            lim = 18'd2822;
        end else if (code <= 4'h7) begin
            lim = 18'd1536;
        end
        return lim;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and sequencer state.
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [3:0] cfg_r, cfg_nxt;
    logic [22:0] sel_r, sel_nxt;
    logic [9:0] mult_r, mult_nxt;
    logic [31:0] frac_r, frac_nxt;
    logic [17:0] refkhz_r, refkhz_nxt;
    logic [5:0] err_r, err_nxt;
    logic intwarn_r, intwarn_nxt;
    logic [1:0] en_r, en_nxt, syn_r, syn_nxt;
    flc_state_t st_r, st_nxt;
    logic [3:0] step_r, step_nxt;
    logic [15:0] wait_r, wait_nxt;
    logic live_r, live_nxt, wasen_r, wasen_nxt, disonly_r, disonly_nxt;
    logic cmd_apply, cmd_disable, commit, mapped, busy;
    logic [17:0] fref;
    logic [4:0] ratio;
    logic [35:0] vco_lo, vco_hi;
    logic [5:0] chk;
    logic loop;
    logic [15:0] base;
    logic [15:0] st_addr, st_data;
    logic st_skip, wr_start, wr_done;
    logic [3:0] gain;

    assign busy = st_r != FLC_IDLE;
    assign commit = psel && penable && pready_r;
    assign cmd_apply = commit && pwrite && paddr == `FLC_REG_CMD && pwdata[`FLC_CMD_APPLY];
    assign cmd_disable = commit && pwrite && paddr == `FLC_REG_CMD && pwdata[`FLC_CMD_DISABLE];
    assign loop = cfg_r[`FLC_CFG_LOOP];
    assign base = loop ? `FLC_DEV_STRIDE : 16'h0000; // R10

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration checks.
    always_comb begin
        fref = refkhz_r >> sel_r[5:4]; // R13
        ratio = {1'b0, sel_r[19:16]} + 5'h01; // R18
        vco_lo = 36'(fref) * 36'(ratio) * 36'(mult_r); // R14
        vco_hi = 36'(fref) * 36'(ratio) * (36'(mult_r) + 36'h1);
        chk[0] = sel_r[22:20] < `FLC_OUTDIV_MIN; // R16
        chk[1] = !src_ok(sel_r[3:0], loop) || !src_ok(sel_r[11:8], loop); // R11
        chk[2] = fref > `FLC_KHZ_REF_MAX; // R13
        chk[3] = fref > ratio_limit(sel_r[19:16]); // R20
        chk[4] = vco_lo > `FLC_KHZ_VCO_MAX || vco_hi < `FLC_KHZ_VCO_MIN; // R15
        chk[5] = cfg_r[`FLC_CFG_SYNC] && !cfg_r[`FLC_CFG_STEADY]; // R01
        if (fref >= `FLC_KHZ_GAIN16) begin
            gain = `FLC_GAIN_X16; // R17
        end else if (fref >= `FLC_KHZ_GAIN4) begin
            gain = `FLC_GAIN_X4; // R17
        end else begin
            gain = `FLC_GAIN_X1; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Step table of the device write sequence.
    always_comb begin
        st_addr = base + `FLC_DEV_CTRL1;
        st_data = 16'h0000;
        st_skip = 1'b0;
        unique case (step_r)
            4'h0: begin
                st_data[`FLC_DEV_ENA_BIT] = 1'b1;
                st_data[`FLC_DEV_FREERUN_BIT] = 1'b1; // R05 R06
                st_skip = !wasen_r;
            end
            4'h1: st_skip = !live_r;
            4'h2: begin
                st_data[`FLC_DEV_FREERUN_BIT] = 1'b1; // R05 R07
                st_skip = live_r || !wasen_r;
            end
            4'h3: begin
                st_addr = base + `FLC_DEV_CTRL2;
                st_data = {6'h00, mult_r}; // R21
                st_skip = disonly_r;
            end
            4'h4: begin
                st_addr = base + `FLC_DEV_CTRL3;
                st_data = frac_r[15:0]; // R21
                st_skip = disonly_r;
            end
            4'h5: begin
                st_addr = base + `FLC_DEV_CTRL4;
                st_data = frac_r[31:16];
                st_skip = disonly_r;
            end
            4'h6: begin
                st_addr = base + `FLC_DEV_CTRL5;
                st_data[`FLC_DEV_RATIO_LSB +: 4] = sel_r[19:16];
                st_data[`FLC_DEV_OUTDIV_LSB +: 3] = sel_r[22:20];
                st_skip = disonly_r;
            end
            4'h7: begin
                st_addr = base + `FLC_DEV_CTRL6;
                st_data[`FLC_DEV_PREDIV_LSB +: 2] = sel_r[5:4];
                st_data[3:0] = sel_r[3:0];
                st_skip = disonly_r;
            end
            4'h8: begin
                st_addr = base + `FLC_DEV_CTRL7;
                st_data[`FLC_DEV_GAIN_LSB +: 4] = gain; // R17
                st_skip = disonly_r;
            end
            4'h9: begin
                st_addr = base + `FLC_DEV_SYNC6;
                st_data[`FLC_DEV_PREDIV_LSB +: 2] = sel_r[13:12];
                st_data[3:0] = sel_r[11:8];
                st_skip = disonly_r;
            end
            4'hA: begin
                st_addr = base + `FLC_DEV_SYNC1;
                st_data[`FLC_DEV_ENA_BIT] = cfg_r[`FLC_CFG_SYNC]; // R03 R22
                st_skip = live_r || disonly_r;
            end
            4'hB: begin
                st_addr = base + `FLC_DEV_CTRL2;
                st_data = {6'h00, mult_r};
                st_data[`FLC_DEV_UPD_BIT] = 1'b1; // R06
                st_skip = !live_r || disonly_r;
            end
            4'hC: begin
                st_data[`FLC_DEV_ENA_BIT] = 1'b1; // R02
                st_skip = disonly_r;
            end
            default: st_skip = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave and sequencer next state.
    always_comb begin
        prdata_nxt = prdata_r;
        pready_nxt = psel && penable && !pready_r;
        pslverr_nxt = 1'b0;
        cfg_nxt = cfg_r;
        sel_nxt = sel_r;
        mult_nxt = mult_r;
        frac_nxt = frac_r;
        refkhz_nxt = refkhz_r;
        err_nxt = err_r;
        intwarn_nxt = intwarn_r;
        en_nxt = en_r;
        syn_nxt = syn_r;
        st_nxt = st_r;
        step_nxt = step_r;
        wait_nxt = wait_r;
        live_nxt = live_r;
        wasen_nxt = wasen_r;
        disonly_nxt = disonly_r;
        wr_start = 1'b0;
        mapped = paddr inside {`FLC_REG_CMD, `FLC_REG_CFG, `FLC_REG_SEL, `FLC_REG_MULT,
            `FLC_REG_FRAC, `FLC_REG_REFKHZ, `FLC_REG_STATUS};
        if (psel && penable && !pready_r) begin
            pslverr_nxt = !mapped;
            unique case (paddr)
                `FLC_REG_CFG: prdata_nxt = {28'h0, cfg_r};
                `FLC_REG_SEL: prdata_nxt = {9'h0, sel_r};
                `FLC_REG_MULT: prdata_nxt = {22'h0, mult_r};
                `FLC_REG_FRAC: prdata_nxt = frac_r;
                `FLC_REG_REFKHZ: prdata_nxt = {14'h0, refkhz_r};
                `FLC_REG_STATUS: prdata_nxt = {16'h0, 2'h0, syn_r, 2'h0, en_r, intwarn_r,
                    err_r, busy};
                default: prdata_nxt = 32'h0000_0000; // R23
            endcase
        end
        if (commit && pwrite && !busy) begin
            unique case (paddr)
                `FLC_REG_CFG: cfg_nxt = pwdata[3:0];
                `FLC_REG_SEL: sel_nxt = pwdata[22:0];
                `FLC_REG_MULT: mult_nxt = pwdata[9:0];
                `FLC_REG_FRAC: frac_nxt = pwdata;
                `FLC_REG_REFKHZ: refkhz_nxt = pwdata[17:0];
                default: ;
            endcase
        end
        unique case (st_r)
            FLC_IDLE: begin
                if (cmd_disable) begin
                    disonly_nxt = 1'b1;
                    live_nxt = 1'b0;
                    wasen_nxt = en_r[loop];
                    step_nxt = 4'h0;
                    st_nxt = FLC_STEP;
                end else if (cmd_apply) begin
                    err_nxt = chk;
                    intwarn_nxt = frac_r[15:0] == 16'h0000; // R19
                    if (chk == 6'h00) begin
                        disonly_nxt = 1'b0;
                        wasen_nxt = en_r[loop];
                        live_nxt = en_r[loop] && cfg_r[`FLC_CFG_LIVE] &&
                            syn_r[loop] == cfg_r[`FLC_CFG_SYNC]; // R03 R07
                        step_nxt = 4'h0;
                        st_nxt = FLC_STEP;
                    end
                end
            end
            FLC_STEP: begin
                if (step_r > `FLC_LAST_STEP) begin
                    st_nxt = FLC_IDLE;
                    en_nxt[loop] = !disonly_r;
                    if (!disonly_r && !live_r) begin
                        syn_nxt[loop] = cfg_r[`FLC_CFG_SYNC];
                    end
                end else if (st_skip) begin
                    step_nxt = step_r + 4'h1;
                end else if (step_r == 4'h1) begin
                    wait_nxt = 16'(SETTLE_CYCLES - 1); // R06
                    st_nxt = FLC_WAIT;
                end else begin
                    wr_start = 1'b1;
                    st_nxt = FLC_WRITE;
                end
            end
            FLC_WRITE: begin
                if (wr_done) begin
                    step_nxt = step_r + 4'h1;
                    st_nxt = FLC_STEP;
                end
            end
            FLC_WAIT: begin
                if (wait_r == 16'h0000) begin
                    step_nxt = step_r + 4'h1;
                    st_nxt = FLC_STEP;
                end else begin
                    wait_nxt = wait_r - 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            cfg_r <= 4'h0;
            sel_r <= {`FLC_RST_OUTDIV, 20'h00000};
            mult_r <= `FLC_RST_N;
            frac_r <= {`FLC_RST_LAMBDA, `FLC_RST_THETA};
            refkhz_r <= 18'h00000;
            err_r <= 6'h00;
            intwarn_r <= 1'b0;
            en_r <= 2'h0;
            syn_r <= 2'h0;
            st_r <= FLC_IDLE;
            step_r <= 4'h0;
            wait_r <= 16'h0000;
            live_r <= 1'b0;
            wasen_r <= 1'b0;
            disonly_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            cfg_r <= cfg_nxt;
            sel_r <= sel_nxt;
            mult_r <= mult_nxt;
            frac_r <= frac_nxt;
            refkhz_r <= refkhz_nxt;
            err_r <= err_nxt;
            intwarn_r <= intwarn_nxt;
            en_r <= en_nxt;
            syn_r <= syn_nxt;
            st_r <= st_nxt;
            step_r <= step_nxt;
            wait_r <= wait_nxt;
            live_r <= live_nxt;
            wasen_r <= wasen_nxt;
            disonly_r <= disonly_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    flc_devwr #(.AW(16), .DW(16)) u_devwr (
        .clk(clk),
        .rst(rst),
        .start(wr_start),
        .addr(st_addr),
        .data(st_data),
        .done(wr_done),
        .dev_req(dev_req),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_ack(dev_ack)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer and the APB ready pulse.
    logic start_seq;
    assign start_seq = st_r == FLC_IDLE && st_nxt == FLC_STEP && !disonly_nxt;

    ena_last_a: assert property (@(posedge clk) disable iff (rst) // R02
        wr_start && st_addr == base + `FLC_DEV_CTRL1 && st_data[`FLC_DEV_ENA_BIT] &&
        !st_data[`FLC_DEV_FREERUN_BIT] |-> step_r == `FLC_LAST_STEP)
        else $error("loop enable written before last step");
    sync_while_off_a: assert property (@(posedge clk) disable iff (rst) // R03
        wr_start && st_addr == base + `FLC_DEV_SYNC1 |-> !live_r && step_r == 4'hA)
        else $error("synchroniser changed with loop enabled");
    freerun_first_a: assert property (@(posedge clk) disable iff (rst) // R05
        wr_start && step_r == 4'h2 |-> st_data[`FLC_DEV_FREERUN_BIT] &&
        !st_data[`FLC_DEV_ENA_BIT])
        else $error("loop disabled without free-run set");
    settle_wait_a: assert property (@(posedge clk) disable iff (rst) // R06
        st_r == FLC_STEP && step_r == 4'h1 && !st_skip |=>
        st_r == FLC_WAIT && wait_r == 16'(SETTLE_CYCLES - 1))
        else $error("settle wait not started at full length");
    upd_live_a: assert property (@(posedge clk) disable iff (rst) // R06
        wr_start && st_data[`FLC_DEV_UPD_BIT] && st_addr == base + `FLC_DEV_CTRL2 |->
        live_r && step_r == 4'hB)
        else $error("update strobe outside live reconfiguration");
    outdiv_ok_a: assert property (@(posedge clk) disable iff (rst) // R16
        start_seq |-> sel_r[22:20] >= `FLC_OUTDIV_MIN)
        else $error("sequence started with reserved output divider");
    ref_limit_a: assert property (@(posedge clk) disable iff (rst) // R20
        start_seq |-> fref <= ratio_limit(sel_r[19:16]) && fref <= `FLC_KHZ_REF_MAX)
        else $error("sequence started above reference limit");
    sync_steady_a: assert property (@(posedge clk) disable iff (rst) // R01
        start_seq && cfg_r[`FLC_CFG_SYNC] |-> cfg_r[`FLC_CFG_STEADY])
        else $error("synchroniser requested without steady reference");
    apb_pulse_a: assert property (@(posedge clk) disable iff (rst)
        psel && penable && !pready_r |=> pready_r ##1 !pready_r)
        else $error("ready not a single cycle answer");
endmodule

// file: testbench/flc_dev_model.sv
// Purpose: Behavioural device side of the loop controller write port.
// Assumes: Loop one control starts at 0x171, loop two one stride above.
// Notes: Acknowledge comes after a delay that the bench sets.
`timescale 1ns/1ps
module flc_dev_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic dev_req,
    input wire logic [15:0] dev_addr,
    input wire logic [15:0] dev_wdata,
    input wire logic [3:0] dly,
    output logic dev_ack
);
    logic [15:0] mem [0:511];
    logic [9:0] n_eff [0:1];
    logic [31:0] last;
    logic fr_seen, fr_clr, hold, l;
    logic [3:0] cnt;
    logic [8:0] c1;
    assign l = dev_addr >= 16'h0191;
    assign c1 = l ? 9'h191 : 9'h171;
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_ack <= 1'b0;
            hold <= 1'b0;
            cnt <= 4'h0;
            fr_seen <= 1'b0;
            fr_clr <= 1'b0;
            n_eff[0] <= 10'h008;
            n_eff[1] <= 10'h008;
            for (int i = 0; i < 512; i++) mem[i] <= 16'h0;
        end else begin
            dev_ack <= 1'b0;
            if (!dev_req) begin
                hold <= 1'b0;
            end else if (!hold && cnt < dly) begin
                cnt <= cnt + 4'h1;
            end else if (!hold) begin
                dev_ack <= 1'b1;
                hold <= 1'b1;
                cnt <= 4'h0;
                mem[dev_addr[8:0]] <= dev_wdata;
                last <= {dev_addr, dev_wdata};
                if (dev_addr[8:0] == c1 + 9'h001) begin
                    if (!mem[c1][0] || dev_wdata[15]) begin
                        n_eff[l] <= dev_wdata[9:0];
                    end
                    if (mem[c1][0]) begin
                        fr_seen <= mem[c1][1];
                    end
                end
                if (dev_addr[8:0] == c1 && mem[c1][0] && !dev_wdata[0]) begin
                    fr_clr <= dev_wdata[1];
                end
            end
        end
    end
endmodule

// file: testbench/flc_ctrl_tb.sv
// Purpose: Self-checking bench for the loop controller.
// Assumes: APB master tasks and a behavioural device model.
// Notes: Settling wait shortened to 8 cycles.
`timescale 1ns/1ps
module flc_ctrl_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, dev_req, dev_ack, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] seed = 32'hC331;
    logic [15:0] dev_addr, dev_wdata;
    logic [9:0] r;
    logic [3:0] dly;
    int n_fail, num_checks;
    int cyc = 0;
    flc_ctrl #(.SETTLE_CYCLES(8)) i_flc_ctrl (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dev_req(dev_req), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_ack(dev_ack));
    flc_dev_model i_flc_dev_model (.clk(clk), .rst(rst), .dev_req(dev_req),
        .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dly(dly), .dev_ack(dev_ack));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        num_checks++;
        if (y !== x) begin
            $display("Error %s expected %h seen %h", s, x, y);
            n_fail++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [31:0] d);
        apb(1'b1, 8'h00, d);
        apb(1'b0, 8'h18, 32'h0);
        while (q[0] !== 1'b0) apb(1'b0, 8'h18, 32'h0);
    endtask
    task summarize;
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        seed <= lfsr(seed);
        dly <= seed[3:0];
        if (cyc == 40000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {n_fail, num_checks} = 64'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        chk("sel", 32'h00200000, q);
        apb(1'b0, 8'h10, 32'h0);
        chk("frac", 32'h007D0018, q);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, 8'h14, 32'd12288);
        apb(1'b1, 8'h08, 32'h00400000);
        apb(1'b1, 8'h10, 32'h03000100);
        for (int i = 0; i < 3; i++) begin
            r = seed[9:0];
            apb(1'b1, 8'h0C, {22'h0, r});
            apb(1'b0, 8'h0C, 32'h0);
            chk("mult", {22'h0, r}, q);
        end
        apb(1'b1, 8'h0C, 32'h7);
        apb(1'b1, 8'h04, 32'h0);
        cmd(32'h1);
        chk("status", 32'h100, q);
        chk("ctrl5", 32'h8, {16'h0, i_flc_dev_model.mem[9'h175]});
        chk("gain", 32'h10, {16'h0, i_flc_dev_model.mem[9'h179]});
        chk("sync", 32'h0, {16'h0, i_flc_dev_model.mem[9'h181]});
        chk("n", 32'h7, {22'h0, i_flc_dev_model.n_eff[0]});
        chk("last", 32'h01710001, i_flc_dev_model.last);
        apb(1'b1, 8'h0C, 32'h8);
        apb(1'b1, 8'h04, 32'h4);
        cmd(32'h1);
        chk("n live", 32'h8, {22'h0, i_flc_dev_model.n_eff[0]});
        chk("free run", 32'h1, {31'h0, i_flc_dev_model.fr_seen});
        apb(1'b1, 8'h08, 32'h00100000);
        cmd(32'h1);
        chk("status err", 32'h102, q);
        apb(1'b1, 8'h10, 32'h03000000);
        apb(1'b1, 8'h14, 32'd27000);
        apb(1'b1, 8'h08, 32'h00410002);
        apb(1'b1, 8'h04, 32'h6);
        cmd(32'h1);
        chk("status err2", 32'h1FC, q);
        apb(1'b1, 8'h08, 32'h00400000);
        cmd(32'h2);
        chk("ctrl1", 32'h2, {16'h0, i_flc_dev_model.mem[9'h171]});
        chk("fr clr", 32'h1, {31'h0, i_flc_dev_model.fr_clr});
        apb(1'b1, 8'h14, 32'd512);
        apb(1'b1, 8'h08, 32'h00410003);
        apb(1'b1, 8'h0C, 32'd90);
        apb(1'b1, 8'h04, 32'h1);
        cmd(32'h1);
        chk("loop2", 32'h01910001, i_flc_dev_model.last);
        chk("n2", 32'd90, {22'h0, i_flc_dev_model.n_eff[1]});
        chk("ctrl5 loop2", 32'h108, {16'h0, i_flc_dev_model.mem[9'h195]});
        chk("gain x4", 32'h8, {16'h0, i_flc_dev_model.mem[9'h199]});
        chk("ctrl6 loop2", 32'h3, {16'h0, i_flc_dev_model.mem[9'h196]});
        summarize();
    end
endmodule
